// file: logic/prwc_power_reset_wake_control.v
// Our own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "prwc_defs.vh"
module prwc_power_reset_wake_control #(
  parameter HOLD_CYC = `PRWC_PHY_HOLD_US * `PRWC_CLK_MHZ,
  parameter SETTLE_CYC = `PRWC_ANA_SETTLE_US * `PRWC_CLK_MHZ
) (
  // Clock and reset
  input wire CLK_SYS,
  input wire RSTN,
  // Avalon-MM slave
  input wire [7:0] AVS_ADDRESS,
  input wire AVS_READ,
  input wire AVS_WRITE,
  input wire [31:0] AVS_WRITEDATA,
  input wire [3:0] AVS_BYTEENABLE,
  output reg [31:0] AVS_READDATA,
  output wire AVS_WAITREQUEST,
  // Device context
  input wire USB_RESET,
  input wire CONFIGURED,
  input wire EXT_PHY,
  input wire IMAGE_VALID,
  input wire IMAGE_OSC_INHIBIT,
  input wire [1:0] IMAGE_PIN_SEL,
  input wire LOAD_BUSY,
  input wire MAC_CLKS_RUNNING,
  input wire PHY_OPERATIONAL,
  // Wake events and resume
  input wire EV_PHY_WAKE,
  input wire EV_FRAME_WAKE,
  input wire EV_ENERGY_WAKE,
  input wire RESUME_DONE,
  input wire RESUME_REMOTE,
  // Controls out
  output reg LITE_RST_OUT,
  output reg FULL_RST_OUT,
  output reg IMAGE_RELOAD,
  output reg USB_PHY_DISCONNECT,
  output reg PHY_RESET_REQUEST_OUT,
  output reg ANA_REF_OFF,
  output reg MAC_RST_OUT,
  output reg OSC_STOP_ALLOWED,
  output reg [1:0] SLEEP_STATE,
  output reg [1:0] SLEEP_PIN_SEL,
  output reg WAKE_REQUEST,
  output reg CLEAR_FRAME_STS
);
  // PHY reset sequencer states
  localparam ST_IDLE = 2'd0;
  localparam ST_HOLD = 2'd1;
  localparam ST_SETTLE = 2'd2;
  localparam ST_WAIT_OP = 2'd3;

  // Bus handshake
  reg ack_ff;
  // Soft reset pulse
  reg lite_ff, full_ff;
  reg [4:0] soft_cnt_ff;
  // Register fields
  reg ana_wait_dis_ff, osc_inhibit_ff, ew_en_ff, ew_sts_ff, mac_rst_ff;
  reg res_clr_sts_ff, res_clr_en_ff, lan_en_ff, phy_en_ff, phy_req_ff;
  reg [1:0] sleep_ff, cause_ff, pin_sel_ff;
  // PHY reset sequencer
  reg [1:0] state_ff;
  reg [23:0] cnt_ff;
  // Status and edge memory
  reg ready_ff;
  reg cfg_ff;

  wire acc = AVS_READ | AVS_WRITE;
  wire wr_pm = AVS_WRITE & ack_ff & (AVS_ADDRESS == `PRWC_OFS_PWR_CTL);
  wire wr_rs = AVS_WRITE & ack_ff & (AVS_ADDRESS == `PRWC_OFS_RESETS);
  wire [31:0] wd = AVS_WRITEDATA;
  wire lo = AVS_BYTEENABLE[0];
  wire hi = AVS_BYTEENABLE[1];
  wire remote_res = RESUME_DONE & RESUME_REMOTE;
  wire restore = USB_RESET | LITE_RST_OUT;
  // Internal PHY is parked in reset while unconfigured; residence in state
  // two belongs to the suspend logic, which sees SLEEP_STATE, because the
  // select field only names the state used at the next suspend
  wire phy_park = ~EXT_PHY & ~CONFIGURED;
  wire phy_start = wr_pm & lo & wd[`PRWC_B_PHY_RESET_REQUEST] & ~phy_req_ff;

  // One wait state: answer on second cycle, keeps decode registered
  // Waitrequest is combinational, so a master must look at it every edge
  assign AVS_WAITREQUEST = acc & ~ack_ff;
  always @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= acc & ~ack_ff;
    end
  end

  // Read mux; unmapped addresses read as zero
  // Captured in the first cycle so the data stands at the answering edge
  always @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      AVS_READDATA <= 32'h0000_0000;
    end else if (AVS_READ & ~ack_ff) begin
      AVS_READDATA <= 32'h0000_0000;
      if (AVS_ADDRESS == `PRWC_OFS_RESETS) begin
        AVS_READDATA[`PRWC_B_LITE_RST] <= lite_ff;
        AVS_READDATA[`PRWC_B_FULL_RST] <= full_ff;
        AVS_READDATA[7:6] <= pin_sel_ff;
      end else if (AVS_ADDRESS == `PRWC_OFS_PWR_CTL) begin
        // Bit ten and everything above fifteen stay zero
        AVS_READDATA[`PRWC_B_ANA_WAIT_DIS] <= ana_wait_dis_ff;
        AVS_READDATA[`PRWC_B_OSC_INHIBIT] <= osc_inhibit_ff;
        AVS_READDATA[`PRWC_B_EW_EN] <= ew_en_ff;
        AVS_READDATA[`PRWC_B_EW_STS] <= ew_sts_ff;
        AVS_READDATA[`PRWC_B_MAC_RST] <= mac_rst_ff;
        AVS_READDATA[`PRWC_B_RES_CLR_STS] <= res_clr_sts_ff;
        AVS_READDATA[`PRWC_B_RES_CLR_EN] <= res_clr_en_ff;
        AVS_READDATA[`PRWC_B_READY] <= ready_ff;
        AVS_READDATA[`PRWC_B_SLEEP_HI:`PRWC_B_SLEEP_LO] <= sleep_ff;
        AVS_READDATA[`PRWC_B_PHY_RESET_REQUEST] <= phy_req_ff;
        AVS_READDATA[`PRWC_B_LAN_WAKE_EN] <= lan_en_ff;
        AVS_READDATA[`PRWC_B_PHY_IRQ_WAKE_ENABLE] <= phy_en_ff;
        AVS_READDATA[`PRWC_B_CAUSE_HI:`PRWC_B_CAUSE_LO] <= cause_ff;
      end
    end
  end

  // Soft resets: a short internal pulse, bit visible until it ends
  // Full wins when both bits are written; writes during a pulse are dropped
  always @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      lite_ff <= 1'b0;
      full_ff <= 1'b0;
      soft_cnt_ff <= 5'h0;
    end else if (lite_ff | full_ff) begin
      soft_cnt_ff <= soft_cnt_ff + 5'h1;
      if (soft_cnt_ff == `PRWC_SOFT_RST_CYC - 1) begin
        lite_ff <= 1'b0;
        full_ff <= 1'b0;
        soft_cnt_ff <= 5'h0;
      end
    end else if (wr_rs & lo) begin
      full_ff <= wd[`PRWC_B_FULL_RST];
      lite_ff <= wd[`PRWC_B_LITE_RST] & ~wd[`PRWC_B_FULL_RST];
    end
  end

  // Reset outputs; lite reset never touches USB link or image reload
  always @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      LITE_RST_OUT <= 1'b0;
      FULL_RST_OUT <= 1'b0;
      IMAGE_RELOAD <= 1'b0;
      USB_PHY_DISCONNECT <= 1'b0;
    end else begin
      LITE_RST_OUT <= lite_ff;
      FULL_RST_OUT <= full_ff;
      IMAGE_RELOAD <= full_ff & (soft_cnt_ff == 5'h0);
      // Stays disconnected until the reload has finished too
      USB_PHY_DISCONNECT <= full_ff
        | (USB_PHY_DISCONNECT & LOAD_BUSY);
    end
  end

  // Image-backed fields, restored on USB or lite reset
  // Restore beats a software write in the same cycle
  always @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      osc_inhibit_ff <= `PRWC_OSC_NO_IMAGE;
      pin_sel_ff <= `PRWC_PIN_SEL_NO_IMAGE;
    end else if (restore) begin
      osc_inhibit_ff <= IMAGE_VALID ? IMAGE_OSC_INHIBIT
                                    : `PRWC_OSC_NO_IMAGE;
      pin_sel_ff <= IMAGE_VALID ? IMAGE_PIN_SEL
                                : `PRWC_PIN_SEL_NO_IMAGE;
    end else if (wr_pm & hi) begin
      osc_inhibit_ff <= wd[`PRWC_B_OSC_INHIBIT];
    end else if (wr_rs & lo) begin
      pin_sel_ff <= wd[7:6];
    end
  end

  // Plain control bits
  // cfg_ff remembers CONFIGURED so that its falling edge can be found
  always @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      ana_wait_dis_ff <= 1'b0;
      mac_rst_ff <= 1'b0;
      res_clr_sts_ff <= 1'b0;
      res_clr_en_ff <= `PRWC_RES_CLR_EN_RST;
      cfg_ff <= 1'b0;
    end else begin
      cfg_ff <= CONFIGURED;
      if (wr_pm & hi) begin
        ana_wait_dis_ff <= wd[`PRWC_B_ANA_WAIT_DIS];
        mac_rst_ff <= wd[`PRWC_B_MAC_RST];
        res_clr_sts_ff <= wd[`PRWC_B_RES_CLR_STS];
        res_clr_en_ff <= wd[`PRWC_B_RES_CLR_EN];
      end
    end
  end

  // Sleep state select; state two is loaded when CONFIGURED falls
  // Codes zero and one are both stored; the alias is applied at the output
  always @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      sleep_ff <= `PRWC_SLEEP_RST;
    end else if (~CONFIGURED & cfg_ff) begin
      sleep_ff <= `PRWC_SLEEP_RST;
    end else if (wr_pm & lo) begin
      sleep_ff <= wd[`PRWC_B_SLEEP_HI:`PRWC_B_SLEEP_LO];
    end
  end

  // Wake enables: cleared by a remote-initiated resume when asked
  // Clear beats a write in the same cycle, so a late write cannot re-arm
  always @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      ew_en_ff <= 1'b0;
      lan_en_ff <= 1'b0;
      phy_en_ff <= 1'b0;
    end else if (remote_res & res_clr_en_ff) begin
      ew_en_ff <= 1'b0;
      lan_en_ff <= 1'b0;
      phy_en_ff <= 1'b0;
    end else begin
      if (wr_pm & hi) begin
        ew_en_ff <= wd[`PRWC_B_EW_EN];
      end
      if (wr_pm & lo) begin
        lan_en_ff <= wd[`PRWC_B_LAN_WAKE_EN];
        phy_en_ff <= wd[`PRWC_B_PHY_IRQ_WAKE_ENABLE];
      end
    end
  end

  // Wake status: events set regardless of enable; a set beats any clear
  // Cleared by writing one, energy status and cause bit one also by a remote resume; host resumes leave status untouched
  always @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      ew_sts_ff <= 1'b0;
      cause_ff <= 2'h0;
    end else begin
      ew_sts_ff <= EV_ENERGY_WAKE | (ew_sts_ff
        & ~(wr_pm & hi & wd[`PRWC_B_EW_STS])
        & ~(remote_res & res_clr_sts_ff));
      cause_ff[0] <= EV_PHY_WAKE | (cause_ff[0]
        & ~(wr_pm & lo & wd[`PRWC_B_CAUSE_LO]));
      // Host resumes never clear; only bit one follows remote resume
      cause_ff[1] <= EV_FRAME_WAKE | (cause_ff[1]
        & ~(wr_pm & lo & wd[`PRWC_B_CAUSE_HI])
        & ~(remote_res & res_clr_sts_ff));
    end
  end

  // PHY reset sequencer; writes ignored while the request is high
  always @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      state_ff <= ST_IDLE;
      cnt_ff <= 24'h00_0000;
      phy_req_ff <= 1'b0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          // A write or parking starts the hold
          cnt_ff <= 24'h00_0000;
          if (phy_start | phy_park) begin
            phy_req_ff <= phy_start;
            state_ff <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          // Hold at least the minimum, and as long as parking lasts
          if (cnt_ff < HOLD_CYC - 1) begin
            cnt_ff <= cnt_ff + 24'h00_0001;
          end else if (~phy_park) begin
            cnt_ff <= 24'h00_0000;
            state_ff <= ana_wait_dis_ff ? ST_WAIT_OP : ST_SETTLE;
          end
        end
        ST_SETTLE: begin
          // Reference was off: extend toward the long settling time
          if (cnt_ff < SETTLE_CYC - HOLD_CYC - 1) begin
            cnt_ff <= cnt_ff + 24'h00_0001;
          end else begin
            state_ff <= ST_WAIT_OP;
          end
        end
        ST_WAIT_OP: begin
          // PHY reset and the request bit drop on the same edge
          phy_req_ff <= 1'b0;
          state_ff <= ST_IDLE;
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
      // A request that lands while parking or settling restarts the hold,
      // so the request bit is never lost and the full minimum is kept
      if (phy_start & (state_ff != ST_IDLE)) begin
        phy_req_ff <= 1'b1;
        cnt_ff <= 24'h00_0000;
        state_ff <= ST_HOLD;
      end
    end
  end

  // Ready: low through PHY sequence and image loading
  // Cleared by the very write that asks for a PHY reset, not a cycle later
  always @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      ready_ff <= 1'b0;
    end else if (phy_start | LOAD_BUSY | (state_ff != ST_IDLE)) begin
      ready_ff <= 1'b0;
    end else if (EXT_PHY) begin
      ready_ff <= 1'b1;
    end else begin
      ready_ff <= PHY_OPERATIONAL & ~phy_park;
    end
  end

  // Outputs to PHY, MAC domains and suspend logic
  always @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      PHY_RESET_REQUEST_OUT <= 1'b1;
      ANA_REF_OFF <= 1'b0;
      MAC_RST_OUT <= 1'b1;
      OSC_STOP_ALLOWED <= 1'b0;
      SLEEP_STATE <= `PRWC_SLEEP_RST;
      SLEEP_PIN_SEL <= `PRWC_PIN_SEL_NO_IMAGE;
      WAKE_REQUEST <= 1'b0;
      CLEAR_FRAME_STS <= 1'b0;
    end else begin
      // Held through hold and settling; drops with the request bit
      PHY_RESET_REQUEST_OUT <= phy_start | (state_ff == ST_HOLD)
        | (state_ff == ST_SETTLE);
      // Reference off only during the hold itself, then left to settle
      ANA_REF_OFF <= (state_ff == ST_HOLD) & ~ana_wait_dis_ff;
      // Release only once software cleared it and clocks run
      // Stopped clocks keep the MAC domains in reset even after software
      MAC_RST_OUT <= mac_rst_ff | ~MAC_CLKS_RUNNING;
      // Crystal may stop in the deep states only when nothing inhibits it
      OSC_STOP_ALLOWED <= ~osc_inhibit_ff;
      // States zero and one share one behaviour downstream
      SLEEP_STATE <= (sleep_ff == 2'h1) ? 2'h0 : sleep_ff;
      SLEEP_PIN_SEL <= pin_sel_ff;
      // Wake request is a level while any enabled status stays set
      WAKE_REQUEST <= (ew_en_ff & ew_sts_ff)
        | (phy_en_ff & cause_ff[0]) | (lan_en_ff & cause_ff[1]);
      CLEAR_FRAME_STS <= remote_res & res_clr_sts_ff;
    end
  end
endmodule

// file: logic/prwc_defs.vh
`ifndef PRWC_DEFS_VH
`define PRWC_DEFS_VH
// Register byte offsets
`define PRWC_OFS_RESETS 8'h10
`define PRWC_OFS_PWR_CTL 8'h14
// Reset-control register fields
`define PRWC_B_LITE_RST 1
`define PRWC_B_FULL_RST 0
// Power management control fields
`define PRWC_B_ANA_WAIT_DIS 15
`define PRWC_B_OSC_INHIBIT 14
`define PRWC_B_EW_EN 13
`define PRWC_B_EW_STS 12
`define PRWC_B_MAC_RST 11
`define PRWC_B_RES_CLR_STS 9
`define PRWC_B_RES_CLR_EN 8
`define PRWC_B_READY 7
`define PRWC_B_SLEEP_HI 6
`define PRWC_B_SLEEP_LO 5
`define PRWC_B_PHY_RESET_REQUEST 4
`define PRWC_B_LAN_WAKE_EN 3
`define PRWC_B_PHY_IRQ_WAKE_ENABLE 2
`define PRWC_B_CAUSE_HI 1
`define PRWC_B_CAUSE_LO 0
// Field reset values
`define PRWC_SLEEP_RST 2'h2
`define PRWC_OSC_NO_IMAGE 1'h1
`define PRWC_PIN_SEL_NO_IMAGE 2'h0
`define PRWC_RES_CLR_EN_RST 1'h1
// Timing in microseconds, clock in MHz
`define PRWC_CLK_MHZ 50
`define PRWC_PHY_HOLD_US 4000
`define PRWC_ANA_SETTLE_US 128000
// Length of the internal lite/full reset pulse in clocks
`define PRWC_SOFT_RST_CYC 16
`endif

// file: verif/prwc_partner.sv
`timescale 1ns/1ps
module prwc_partner (
  // Clock and reset
  input wire clk_sys,
  input wire rstn,
  // From the block
  input wire phy_reset_request,
  // Toward the block
  output reg phy_op,
  output reg mac_clks,
  output reg [2:0] ev,
  output reg resume_done,
  output reg resume_remote
);
  integer up_cnt;
  reg hold_clks;
  // PHY reports operational a few clocks after its reset drops
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      up_cnt <= 0;
      phy_op <= 1'b0;
      mac_clks <= 1'b0;
    end else begin
      up_cnt <= phy_reset_request ? 0 : up_cnt + 1;
      phy_op <= !phy_reset_request && up_cnt >= 3;
      mac_clks <= !hold_clks;
    end
  end
  // One-clock event: bit 0 PHY, bit 1 frame, bit 2 energy
  task pulse_ev(input [2:0] which);
    begin
      @(posedge clk_sys);
      ev <= which;
      @(posedge clk_sys);
      ev <= 3'h0;
    end
  endtask
  // Origin qualifier held on both sides of the done pulse
  task resume(input remote);
    begin
      @(posedge clk_sys);
      resume_remote <= remote;
      @(posedge clk_sys);
      resume_done <= 1'b1;
      @(posedge clk_sys);
      resume_done <= 1'b0;
      repeat (3) @(posedge clk_sys);
      resume_remote <= 1'b0;
    end
  endtask
  // Quiet until a scenario asks
  initial begin
    ev = 3'h0;
    resume_done = 1'b0;
    resume_remote = 1'b0;
    hold_clks = 1'b0;
  end
endmodule

// file: verif/prwc_asserts.sv
`timescale 1ns/1ps
module prwc_asserts #(
  parameter HOLD_CYC = 200000
) (
  // Clock and reset
  input wire CLK_SYS,
  input wire RSTN,
  // Register bus
  input wire [7:0] AVS_ADDRESS,
  input wire AVS_READ,
  input wire AVS_WRITE,
  input wire [31:0] AVS_WRITEDATA,
  input wire [3:0] AVS_BYTEENABLE,
  input wire [31:0] AVS_READDATA,
  input wire AVS_WAITREQUEST,
  // Context
  input wire CONFIGURED,
  input wire MAC_CLKS_RUNNING,
  input wire RESUME_REMOTE,
  // Controls
  input wire LITE_RST_OUT,
  input wire FULL_RST_OUT,
  input wire IMAGE_RELOAD,
  input wire USB_PHY_DISCONNECT,
  input wire PHY_RESET_REQUEST_OUT,
  input wire ANA_REF_OFF,
  input wire MAC_RST_OUT,
  input wire [1:0] SLEEP_STATE,
  input wire CLEAR_FRAME_STS
);
  integer hold_cnt;
  default clocking @(posedge CLK_SYS);
  endclocking
  default disable iff (!RSTN);
  // Reset itself counts as a long enough hold, so no false hit after it
  always @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      hold_cnt <= HOLD_CYC;
    end else begin
      hold_cnt <= PHY_RESET_REQUEST_OUT ? hold_cnt + 1 : 0;
    end
  end
  // Bus steps and the lite pulse shape the checks are built from
  sequence s_phy_go;
    AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == 8'h14 &&
    AVS_WRITEDATA[4] && AVS_BYTEENABLE[0] && !PHY_RESET_REQUEST_OUT;
  endsequence
  sequence s_rd_busy;
    AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == 8'h14 && PHY_RESET_REQUEST_OUT;
  endsequence
  sequence s_lite16;
    LITE_RST_OUT[*8] ##1 LITE_RST_OUT[*8] ##1 !LITE_RST_OUT;
  endsequence
  chk_phy_start: assert property (s_phy_go |=> PHY_RESET_REQUEST_OUT)
    else $error("PHY reset did not follow the write");
  chk_phy_hold: assert property (
    $fell(PHY_RESET_REQUEST_OUT) |-> hold_cnt >= HOLD_CYC)
    else $error("PHY reset released too early");
  chk_ref_off: assert property (ANA_REF_OFF |-> PHY_RESET_REQUEST_OUT)
    else $error("reference off outside PHY reset");
  chk_ready_low: assert property (s_rd_busy |=> !AVS_READDATA[7])
    else $error("ready read high during PHY reset");
  chk_lite_len: assert property ($rose(LITE_RST_OUT) |-> s_lite16)
    else $error("lite reset pulse length wrong");
  chk_lite_spare: assert property (
    LITE_RST_OUT |-> !IMAGE_RELOAD && !USB_PHY_DISCONNECT)
    else $error("lite reset touched USB side");
  chk_full_load: assert property (
    $rose(FULL_RST_OUT) |-> ##[0:17] IMAGE_RELOAD)
    else $error("full reset gave no image reload");
  chk_mac_hold: assert property (
    $fell(MAC_RST_OUT) |-> $past(MAC_CLKS_RUNNING))
    else $error("MAC reset released with clocks stopped");
  chk_sleep_unconf: assert property (
    $fell(CONFIGURED) |-> ##[1:2] SLEEP_STATE == 2'h2)
    else $error("sleep state not two when unconfigured");
  chk_frame_clr: assert property (
    CLEAR_FRAME_STS |-> $past(RESUME_REMOTE))
    else $error("frame status cleared on host resume");
  chk_sleep_alias: assert property (SLEEP_STATE != 2'h1)
    else $error("state one not shown as state zero");
endmodule
bind prwc_power_reset_wake_control prwc_asserts #(.HOLD_CYC(HOLD_CYC))
  u_prwc_asserts (.CLK_SYS, .RSTN, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE,
  .AVS_WRITEDATA, .AVS_BYTEENABLE, .AVS_READDATA, .AVS_WAITREQUEST,
  .CONFIGURED, .MAC_CLKS_RUNNING, .RESUME_REMOTE, .LITE_RST_OUT,
  .FULL_RST_OUT, .IMAGE_RELOAD, .USB_PHY_DISCONNECT, .PHY_RESET_REQUEST_OUT,
  .ANA_REF_OFF, .MAC_RST_OUT, .SLEEP_STATE, .CLEAR_FRAME_STS);

// file: verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  reg clk_sys, rstn, rd, wr, usb_rst, cfgd, img, ext, load, img_osc;
  reg [7:0] addr;
  reg [31:0] wdata, rdat;
  integer failures, check_count, cyc, i;
  wire wq, phy_reset_request, phy_op, mac_clks, res_done, res_rem, lite, full;
  wire reload, disc, mac_rst, clr_frm, ana_off, osc_stop, wake;
  wire [2:0] ev;
  wire [31:0] rdata;
  wire [1:0] sleep, pin_sel;
  // Short PHY hold and settle so the run stays brief
  prwc_power_reset_wake_control #(.HOLD_CYC(20), .SETTLE_CYC(60))
    u_prwc_power_reset_wake_control (.CLK_SYS(clk_sys), .RSTN(rstn),
    .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'h3), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(wq), .USB_RESET(usb_rst), .CONFIGURED(cfgd),
    .EXT_PHY(ext), .IMAGE_VALID(img), .IMAGE_OSC_INHIBIT(img_osc),
    .IMAGE_PIN_SEL(2'h1), .LOAD_BUSY(load), .MAC_CLKS_RUNNING(mac_clks),
    .PHY_OPERATIONAL(phy_op), .EV_PHY_WAKE(ev[0]), .EV_FRAME_WAKE(ev[1]),
    .EV_ENERGY_WAKE(ev[2]), .RESUME_DONE(res_done),
    .RESUME_REMOTE(res_rem), .LITE_RST_OUT(lite), .FULL_RST_OUT(full),
    .IMAGE_RELOAD(reload), .USB_PHY_DISCONNECT(disc),
    .PHY_RESET_REQUEST_OUT(phy_reset_request), .ANA_REF_OFF(ana_off), .MAC_RST_OUT(mac_rst),
    .OSC_STOP_ALLOWED(osc_stop), .SLEEP_STATE(sleep),
    .SLEEP_PIN_SEL(pin_sel), .WAKE_REQUEST(wake),
    .CLEAR_FRAME_STS(clr_frm));
  prwc_partner u_prwc_partner (.clk_sys(clk_sys), .rstn(rstn),
    .phy_reset_request(phy_reset_request), .phy_op(phy_op), .mac_clks(mac_clks), .ev(ev),
    .resume_done(res_done), .resume_remote(res_rem));
  // 50 MHz clock and a cycle count for timing checks
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) cyc <= cyc + 1;
  task check(input [31:0] got, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  // One bus cycle; request held until waitrequest is seen low
  task bus(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge clk_sys);
      addr <= a;
      wdata <= d;
      wr <= w;
      rd <= !w;
      @(posedge clk_sys iff wq === 1'b0);
      rdat = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
    end
  endtask
  // PHY reset length bounded by lo and hi; second write must be ignored
  task t_phy(input [15:0] v, input integer lo, input integer hi);
    integer t0;
    begin
      bus(1, 8'h14, v);
      t0 = cyc;
      bus(0, 8'h14, 0);
      check(rdat[7:4], 4'h5);
      check(ana_off, !v[15]);
      bus(1, 8'h14, v);
      while (rdat[4] === 1'b1) bus(0, 8'h14, 0);
      check(cyc - t0 >= lo && cyc - t0 <= hi, 1);
      repeat (6) @(posedge clk_sys);
      bus(0, 8'h14, 0);
      check(rdat[7:4], 4'hC);
    end
  endtask
  // Status sets without enables, remote resume clears but host resume does not, a write clears bit zero
  task t_wake;
    begin
      bus(1, 8'h14, 32'h0000_0340);
      u_prwc_partner.pulse_ev(3'h7);
      bus(0, 8'h14, 0);
      check(rdat & 32'h0000_330F, 32'h0000_1303);
      bus(1, 8'h14, 32'h0000_234C);
      u_prwc_partner.resume(1'b0);
      bus(0, 8'h14, 0);
      check(rdat & 32'h0000_330F, 32'h0000_330F);
      check(wake, 1'b1);
      u_prwc_partner.resume(1'b1);
      bus(0, 8'h14, 0);
      check(rdat & 32'h0000_330F, 32'h0000_0301);
      check(wake, 1'b0);
      bus(1, 8'h14, 32'h0000_0341);
      bus(0, 8'h14, 0);
      check(rdat & 32'h0000_330F, 32'h0000_0300);
    end
  endtask
  // Lite reset restores image fields; full reset drops the USB link
  task t_soft;
    begin
      bus(1, 8'h10, 32'h0000_00C2);
      bus(0, 8'h10, 0);
      check({rdat[1], disc}, 2'b10);
      repeat (20) @(posedge clk_sys);
      bus(0, 8'h10, 0);
      check(rdat[1], 1'b0);
      bus(0, 8'h14, 0);
      check({rdat[14], pin_sel}, 3'b100);
      check(osc_stop, 1'b0);
      img <= 1'b1;
      bus(1, 8'h10, 32'h0000_00C2);
      repeat (20) @(posedge clk_sys);
      bus(0, 8'h14, 0);
      check({rdat[14], pin_sel}, 3'b001);
      check(osc_stop, 1'b1);
      img <= 1'b0;
      usb_rst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      usb_rst <= 1'b0;
      repeat (2) @(posedge clk_sys);
      check(pin_sel, 2'h0);
      load <= 1'b1;
      bus(1, 8'h10, 32'h0000_0001);
      bus(0, 8'h10, 0);
      check({rdat[0], disc}, 2'b11);
      repeat (20) @(posedge clk_sys);
      bus(0, 8'h10, 0);
      check({rdat[0], disc}, 2'b01);
      bus(0, 8'h14, 0);
      check(rdat[7], 1'b0);
      load <= 1'b0;
      repeat (2) @(posedge clk_sys);
      bus(0, 8'h14, 0);
      check({rdat[7], disc}, 2'b10);
    end
  endtask
  // Every sleep code, MAC reset, then unconfigured forces state two
  task t_sleep;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        bus(1, 8'h14, 32'h0000_0B00 | (i << 5));
        repeat (2) @(posedge clk_sys);
        check({mac_rst, sleep}, 4 + ((i == 1) ? 0 : i));
      end
      u_prwc_partner.hold_clks <= 1'b1;
      bus(1, 8'h14, 32'h0000_0320);
      repeat (2) @(posedge clk_sys);
      check(mac_rst, 1'b1);
      u_prwc_partner.hold_clks <= 1'b0;
      repeat (3) @(posedge clk_sys);
      check(mac_rst, 1'b0);
      cfgd <= 1'b0;
      repeat (3) @(posedge clk_sys);
      bus(0, 8'h14, 0);
      check({sleep, rdat[7:5]}, 5'h12);
      ext <= 1'b1;
      repeat (80) @(posedge clk_sys);
      bus(0, 8'h14, 0);
      check(rdat[7], 1'b1);
    end
  endtask
  task stop_test;
    begin
      $display("failures=%0d check_count=%0d", failures, check_count);
      if (failures == 0 && check_count > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  // Watchdog far beyond the expected run length
  initial begin
    #200000;
    failures = failures + 1;
    $display("unexpected at %0t: watchdog expired", $time);
    stop_test;
  end
  // Main sequence
  initial begin
    failures = 0;
    check_count = 0;
    cyc = 0;
    {rstn, rd, wr, usb_rst, cfgd, img} = 6'h0;
    {ext, load, img_osc} = 3'h0;
    addr = 8'h00;
    wdata = 32'h0000_0000;
    repeat (6) @(posedge clk_sys);
    rstn <= 1'b1;
    bus(0, 8'h14, 0);
    check(rdat, 32'h0000_4140);
    bus(0, 8'h20, 0);
    check(rdat, 32'h0000_0000);
    cfgd <= 1'b1;
    t_phy(16'h8150, 20, 40);
    t_wake;
    t_phy(16'h0150, 60, 90);
    t_soft;
    t_sleep;
    stop_test;
  end
endmodule
